// *** logic/pch_config_regs.sv ***
/*
 * PCI configuration header slice: class code, misc header fields, register
 * space base and messaging-unit window base, plus address hit decoding.
 * Assumes config and local-bus accesses arrive as one-cycle strobes on the
 * PCI clock, and messaging_unit_enable_in is driven by same-clock logic.
 */
`timescale 1ns/100ps

// Notes on behaviour
// - base class resets to bridge, may become 0E; sub class 80, reads 00 then.
// - interface code resets 00; 01 under 0E also advertises interrupt registers.
// - not self-test capable; capable, start and completion bits always read zero.
// - multifunction flag and header layout field always read zero.
// - latency writable in bits 7..1; floor and default mean eight clocks.
// - as master, terminate once programmed latency clocks have elapsed.
// - line size keeps 01, 10 or 00; any other code stores zero.
// - line size 00 behaves as a four-word line.
// - line size steers target burst writes and DMA data on PCI.
// - register space base holds 4K-aligned address; space bit reads zero.
// - register space is 4K; hit selects register by address bits 11..0.
// - with messaging unit on, register base moves to 018, window at 010.
// - register space unreachable from PCI until its base is written.
// - window base holds bits 31..12 writable, space bit reads zero.
// - lowest 4K of window reserved; above forwards to local-bus memory.
// - locally writable class fields load from serial memory or local bus only.
module pch_config_regs (
    input  wire logic                      clock_in,
    input  wire logic                      rst_b_in,
    input  wire pch_pkg::pch_access_type   cfg_in,
    input  wire pch_pkg::pch_access_type   local_bus_in,
    input  wire pch_pkg::pch_eeprom_type   eeprom_in,
    input  wire pch_pkg::pch_pci_addr_type pci_addr_in,
    input  wire logic                      messaging_unit_enable_in,
    input  wire logic                      master_active_in,
    output logic [31:0]                    cfg_rdata_out,
    output logic                           cfg_ack_out,
    output logic [31:0]                    local_bus_rdata_out,
    output logic                           local_bus_ack_out,
    output logic                           reg_hit_out,
    output logic [11:0]                    reg_index_out,
    output logic                           i2o_forward_out,
    output logic                           i2o_reserved_out,
    output logic                           i2o_queues_out,
    output logic                           i2o_intr_regs_out,
    output logic                           line_eight_out,
    output logic                           latency_expired_out
);
    import pch_pkg::*;

    logic [7:0]  base_class;
    logic [7:0]  sub_class;
    logic [7:0]  interface_code_a;
    logic [6:0]  master_latency_count;
    logic [1:0]  line_size_code;
    logic [19:0] space_ba;
    logic        space_written;
    logic [19:0] window_ba = BA_RST;

    wire        mu_en     = messaging_unit_enable_in;
    wire [7:0]  space_off = mu_en ? ADDR_BAR2 : ADDR_BAR0;

    wire cfg_class  = cfg_in.addr == ADDR_CLASS;
    wire cfg_misc   = cfg_in.addr == ADDR_MISC;
    wire cfg_space  = cfg_in.addr == space_off;
    wire cfg_window = mu_en && (cfg_in.addr == ADDR_BAR0);
    wire lb_class   = local_bus_in.addr == ADDR_CLASS;
    wire lb_misc    = local_bus_in.addr == ADDR_MISC;
    wire lb_space   = local_bus_in.addr == space_off;
    wire lb_window  = mu_en && (local_bus_in.addr == ADDR_BAR0);

    // sub class forced to 00 under 0E
    wire [7:0]  sub_view   = (base_class == BASE_I2O) ? SUB_I2O : sub_class;
    wire [31:0] class_word = {base_class, sub_view, interface_code_a, REVISION_VALUE};
    // partial local writes keep the stored sub class
    wire [31:0] class_store = {base_class, sub_class, interface_code_a, REVISION_VALUE};
    wire [31:0] misc_word  = {16'h0000, master_latency_count, 1'b0,
                              4'h0, line_size_code, 2'h0};
    wire [31:0] space_word  = {space_ba, 12'h000};
    wire [31:0] window_word = {window_ba, 12'h000};

    function automatic logic [31:0] read_word(input logic [7:0] a);
        if (a == ADDR_CLASS) return class_word;
        if (a == ADDR_MISC) return misc_word;
        if (a == space_off) return space_word;
        if (mu_en && a == ADDR_BAR0) return window_word;
        return 32'h00000000;
    endfunction

    wire [31:0] cfg_rd_word = read_word(cfg_in.addr);
    wire [31:0] lb_rd_word  = read_word(local_bus_in.addr);

    wire [31:0] cfg_misc_m = merge_be(misc_word, cfg_in.wdata, cfg_in.be);
    wire [31:0] lb_misc_m  = merge_be(misc_word, local_bus_in.wdata, local_bus_in.be);
    wire [31:0] lb_class_m = merge_be(class_store, local_bus_in.wdata, local_bus_in.be);
    wire [31:0] cfg_space_m = merge_be(space_word, cfg_in.wdata, cfg_in.be);
    wire [31:0] lb_space_m  = merge_be(space_word, local_bus_in.wdata, local_bus_in.be);
    wire [31:0] cfg_win_m   = merge_be(window_word, cfg_in.wdata, cfg_in.be);
    wire [31:0] lb_win_m    = merge_be(window_word, local_bus_in.wdata, local_bus_in.be);

    wire cfg_misc_wr  = cfg_in.wr && cfg_misc;
    wire lb_misc_wr   = local_bus_in.wr && lb_misc;
    wire lb_class_wr  = local_bus_in.wr && lb_class;
    wire cfg_space_wr = cfg_in.wr && cfg_space && (cfg_in.be[3:1] != 3'h0);
    wire lb_space_wr  = local_bus_in.wr && lb_space && (local_bus_in.be[3:1] != 3'h0);
    wire cfg_win_wr   = cfg_in.wr && cfg_window;
    wire lb_win_wr    = local_bus_in.wr && lb_window;

    // local bus wins when both write the same field
    wire [31:0] misc_m  = lb_misc_wr ? lb_misc_m : cfg_misc_m;
    wire [31:0] space_m = lb_space_wr ? lb_space_m : cfg_space_m;
    wire [31:0] win_m   = lb_win_wr ? lb_win_m : cfg_win_m;

    wire [1:0] line_size_code_wr  = misc_m[LINE_SIZE_CODE_LSB +: 2];
    wire [1:0] line_size_code_new = (line_size_code_wr == 2'h3) ? LINE_SIZE_CODE_TREATED : line_size_code_wr;

    // base accepts only bridge or I2O codes
    wire [7:0] base_src  = eeprom_in.load ? eeprom_in.base_class : lb_class_m[31:24];
    wire       base_ok   = (base_src == BASE_BRIDGE) || (base_src == BASE_I2O);
    wire       class_upd = eeprom_in.load || lb_class_wr;

    // class fields: serial load or local bus, never PCI
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            base_class       <= BASE_BRIDGE;
            sub_class        <= SUB_RST;
            interface_code_a <= INTERFACE_CODE_A_RST;
        end else if (class_upd) begin
            if (base_ok) base_class <= base_src;
            sub_class        <= eeprom_in.load ? eeprom_in.sub_class : lb_class_m[23:16];
            interface_code_a <= eeprom_in.load ? eeprom_in.interface_code_a
                                               : lb_class_m[15:8];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            master_latency_count <= LAT_RST;
            line_size_code       <= LINE_SIZE_CODE_RST;
        end else if (cfg_misc_wr || lb_misc_wr) begin
            master_latency_count <= misc_m[LAT_LSB +: 7];
            line_size_code       <= line_size_code_new;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            space_ba      <= BA_RST;
            space_written <= 1'b0;
        end else if (cfg_space_wr || lb_space_wr) begin
            space_ba      <= space_m[31:BA_LSB];
            space_written <= 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (cfg_win_wr || lb_win_wr) begin
            window_ba <= win_m[31:BA_LSB];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            cfg_rdata_out       <= 32'h00000000;
            cfg_ack_out         <= 1'b0;
            local_bus_rdata_out <= 32'h00000000;
            local_bus_ack_out   <= 1'b0;
        end else begin
            cfg_rdata_out       <= cfg_in.rd ? cfg_rd_word : 32'h00000000;
            cfg_ack_out         <= cfg_in.rd || cfg_in.wr;
            local_bus_rdata_out <= local_bus_in.rd ? lb_rd_word : 32'h00000000;
            local_bus_ack_out   <= local_bus_in.rd || local_bus_in.wr;
        end
    end

    wire space_hit = pci_addr_in.valid && space_written &&
                     (pci_addr_in.addr[31:BA_LSB] == space_ba);
    wire win_hit   = pci_addr_in.valid && mu_en &&
                     (pci_addr_in.addr[31:I2O_WIN_LSB] == window_ba[19:4]);
    wire win_low   = pci_addr_in.addr[I2O_WIN_LSB-1:BA_LSB] == 4'h0;

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            reg_hit_out       <= 1'b0;
            reg_index_out     <= 12'h000;
            i2o_forward_out   <= 1'b0;
            i2o_reserved_out  <= 1'b0;
            i2o_queues_out    <= 1'b0;
            i2o_intr_regs_out <= 1'b0;
            line_eight_out    <= 1'b0;
        end else begin
            reg_hit_out       <= space_hit;
            reg_index_out     <= pci_addr_in.addr[BA_LSB-1:0];
            i2o_forward_out   <= win_hit && !win_low;
            i2o_reserved_out  <= win_hit && win_low;
            i2o_queues_out    <= base_class == BASE_I2O;
            i2o_intr_regs_out <= (base_class == BASE_I2O) &&
                                 (interface_code_a == INTERFACE_CODE_A_I2O_INTR);
            line_eight_out    <= line_size_code == LINE_SIZE_CODE_EIGHT;
        end
    end

    pch_master_timer u_timer (
        .clock_in         (clock_in),
        .rst_b_in         (rst_b_in),
        .master_active_in (master_active_in),
        .limit_in         (lat_clocks(master_latency_count)),
        .expired_out      (latency_expired_out)
    );

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    AST_CLASS_RESET: assert property (
        !$past(rst_b_in) |-> base_class == BASE_BRIDGE && sub_class == SUB_RST)
        else $error("class code not at reset value");
    AST_SUB_UNDER_I2O: assert property (
        cfg_in.rd && cfg_class && base_class == BASE_I2O |=> cfg_rdata_out[23:16] == 8'h00)
        else $error("sub class not zero under I2O base");
    AST_INTR_ADVERT: assert property (
        lb_class_wr && !eeprom_in.load && lb_class_m[31:8] == 24'h0e0001
        |=> ##1 i2o_intr_regs_out && i2o_queues_out)
        else $error("interrupt registers not advertised");
    AST_MISC_UPPER_ZERO: assert property (
        cfg_in.rd && cfg_misc |=> cfg_rdata_out[31:16] == 16'h0000)
        else $error("self-test or layout bits not zero");
    AST_LAT_BIT0: assert property (
        cfg_misc_wr && !lb_misc_wr && cfg_in.be[1]
        |=> master_latency_count == $past(cfg_in.wdata[15:9]) && misc_word[8] == 1'b0)
        else $error("latency field write or bit 0 wrong");
    AST_LINE_SIZE_CODE_BAD: assert property (
        (cfg_misc_wr || lb_misc_wr) && misc_m[3:2] == 2'h3 |=> line_size_code == 2'h0)
        else $error("illegal line size code kept");
    AST_LINE_FOUR: assert property (
        line_size_code != LINE_SIZE_CODE_EIGHT |=> !line_eight_out)
        else $error("eight-word line without code 10");
    AST_HIT_GATED: assert property (
        !space_written |=> !reg_hit_out)
        else $error("register hit before base written");
    AST_HIT_INDEX: assert property (
        space_hit |=> reg_hit_out && reg_index_out == $past(pci_addr_in.addr[11:0]))
        else $error("register hit index wrong");
    AST_WIN_SPLIT: assert property (
        win_hit |=> i2o_forward_out != i2o_reserved_out &&
                    i2o_reserved_out == ($past(pci_addr_in.addr[15:12]) == 4'h0))
        else $error("window access split at 4K wrong");
    AST_PCI_NO_CLASS: assert property (
        !class_upd |=> $stable(base_class) && $stable(interface_code_a))
        else $error("class field changed without local write");
    AST_BAR_SWAP: assert property (
        mu_en && cfg_in.rd && cfg_in.addr == ADDR_BAR2
        |=> cfg_rdata_out == {$past(space_ba), 12'h000})
        else $error("relocated register base read wrong");
    AST_SPACE_WRITE: assert property (
        cfg_space_wr && !lb_space_wr && cfg_in.be == 4'hf
        |=> space_written && space_ba == $past(cfg_in.wdata[31:12]))
        else $error("register space base write lost");
    AST_SPACE_RESET: assert property (
        !$past(rst_b_in) |-> !space_written && space_ba == BA_RST)
        else $error("register space base not cleared by reset");
    AST_WINDOW_KEEP: assert property (@(posedge clock_in) disable iff (1'b0)
        !rst_b_in && !cfg_win_wr && !lb_win_wr |=> window_ba == $past(window_ba))
        else $error("window base disturbed by reset");
    AST_WINDOW_OFF: assert property (
        !mu_en |=> !i2o_forward_out && !i2o_reserved_out)
        else $error("window hit while messaging unit off");
    AST_RESERVED_READ: assert property (
        cfg_in.rd && !(cfg_class || cfg_misc || cfg_space || cfg_window)
        |=> cfg_rdata_out == 32'h00000000)
        else $error("unmapped offset read not zero");
    AST_LINE_SIZE_CODE_GOOD: assert property (
        cfg_misc_wr && !lb_misc_wr && cfg_in.be[0] && cfg_in.wdata[3:2] != 2'h3
        |=> line_size_code == $past(cfg_in.wdata[3:2]))
        else $error("legal line size code not stored");
    AST_LINE_EIGHT: assert property (
        line_size_code == LINE_SIZE_CODE_EIGHT |=> line_eight_out)
        else $error("eight-word line not signalled");
    AST_QUEUES: assert property (
        base_class == BASE_I2O |=> i2o_queues_out)
        else $error("message queues not advertised");
    AST_INTR_OFF: assert property (
        interface_code_a != INTERFACE_CODE_A_I2O_INTR |=> !i2o_intr_regs_out)
        else $error("interrupt registers advertised without code 01");
    AST_SUB_KEEP: assert property (
        cfg_in.wr && cfg_class && !class_upd |=> $stable(sub_class))
        else $error("sub class changed by configuration write");

    COV_SPACE_HIT: cover property (reg_hit_out);
    COV_I2O_RSVD:  cover property (i2o_reserved_out);
    COV_I2O_FWD:   cover property (i2o_forward_out);
    COV_LINE8:     cover property (line_eight_out);

endmodule // pch_config_regs

// *** logic/pch_pkg.sv ***
/*
 * Shared constants and carrier types for the PCI configuration header slice:
 * register offsets, field positions, reset values, line-size codes.
 * Assumes one 125 MHz PCI-side clock and dword-aligned configuration offsets.
 */
package pch_pkg;

    // dword offsets inside configuration space
    localparam logic [7:0] ADDR_CLASS = 8'h08;
    localparam logic [7:0] ADDR_MISC  = 8'h0c;
    localparam logic [7:0] ADDR_BAR0  = 8'h10;
    localparam logic [7:0] ADDR_BAR2  = 8'h18;

    // class code fields
    localparam logic [7:0] BASE_BRIDGE    = 8'h06;
    localparam logic [7:0] BASE_I2O       = 8'h0e;
    localparam logic [7:0] SUB_RST        = 8'h80;
    localparam logic [7:0] SUB_I2O        = 8'h00;
    localparam logic [7:0] INTERFACE_CODE_A_RST       = 8'h00;
    localparam logic [7:0] INTERFACE_CODE_A_I2O_INTR  = 8'h01;
    // arbitrary neutral revision value
    localparam logic [7:0] REVISION_VALUE = 8'h5a;

    // miscellaneous register fields
    localparam int         LAT_LSB        = 9;
    localparam int         LINE_SIZE_CODE_LSB      = 2;
    localparam logic [6:0] LAT_RST        = 7'h00;
    localparam logic [7:0] LAT_MIN_CLOCKS = 8'h08;
    localparam logic [1:0] LINE_SIZE_CODE_RST      = 2'h0;
    localparam logic [1:0] LINE_SIZE_CODE_TREATED  = 2'h0;
    localparam logic [1:0] LINE_SIZE_CODE_FOUR     = 2'h1;
    localparam logic [1:0] LINE_SIZE_CODE_EIGHT    = 2'h2;

    // base address registers
    localparam int          BA_LSB        = 12;
    localparam int          I2O_WIN_LSB   = 16;
    localparam logic [19:0] BA_RST        = 20'h00000;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } pch_access_type;

    typedef struct packed {
        logic       load;
        logic [7:0] base_class;
        logic [7:0] sub_class;
        logic [7:0] interface_code_a;
    } pch_eeprom_type;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } pch_pci_addr_type;

    typedef enum logic [2:0] {
        TMR_IDLE    = 3'b001,
        TMR_COUNT   = 3'b010,
        TMR_EXPIRED = 3'b100
    } pch_timer_state_type;

    // byte-enable merge of a write onto a stored word
    function automatic logic [31:0] merge_be(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // effective latency in clocks, never below the floor
    function automatic logic [7:0] lat_clocks(input logic [6:0] lat);
        logic [7:0] v;
        v = {lat, 1'b0};
        return (v < LAT_MIN_CLOCKS) ? LAT_MIN_CLOCKS : v;
    endfunction

endpackage

// *** logic/pch_master_timer.sv ***
/*
 * Master latency timer: counts PCI clocks of an owned transaction and
 * flags when the programmed latency has elapsed.
 * Assumes master_active_in comes from logic on the same clock.
 */
`timescale 1ns/100ps
module pch_master_timer (
    input  wire logic       clock_in,
    input  wire logic       rst_b_in,
    input  wire logic       master_active_in,
    input  wire logic [7:0] limit_in,
    output logic            expired_out
);
    import pch_pkg::*;

    pch_timer_state_type state;
    pch_timer_state_type next_state;
    logic [7:0]          count;
    wire                 reach = (count + 8'h01) >= limit_in;

    always_comb begin
        next_state = state;
        case (state)
            TMR_IDLE:    if (master_active_in) next_state = TMR_COUNT;
            TMR_COUNT: begin
                if (!master_active_in) next_state = TMR_IDLE;
                else if (reach) next_state = TMR_EXPIRED;
            end
            TMR_EXPIRED: if (!master_active_in) next_state = TMR_IDLE;
            default:     next_state = TMR_IDLE;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            state       <= TMR_IDLE;
            count       <= 8'h00;
            expired_out <= 1'b0;
        end else begin
            state       <= next_state;
            count       <= (next_state == TMR_COUNT) ? count + 8'h01 : 8'h00;
            expired_out <= (next_state == TMR_EXPIRED);
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    AST_LAT_NOT_EARLY: assert property (
        $rose(expired_out) |-> $past(master_active_in, 1) && $past(master_active_in, 8))
        else $error("latency expiry before eight owned clocks");
    AST_LAT_DROP: assert property (
        !master_active_in |=> !expired_out)
        else $error("latency expiry held after master released bus");
    COV_LAT_EXPIRE: cover property ($rose(expired_out));

endmodule // pch_master_timer

// *** test/pch_host_model.sv ***
/*
 * Behavioural PCI host issuing configuration reads and writes to the
 * configuration header slice. Assumes one-cycle request strobes and an
 * answer registered one clock after the request edge.
 */
`timescale 1ns/100ps
module pch_host_model
    import pch_pkg::*;
(
    input  wire logic              clock_in,
    input  wire logic [31:0]       rdata_in,
    input  wire logic              ack_in,
    output pch_pkg::pch_access_type cfg_out
);

    initial cfg_out = '0;

    // one-cycle request, answer taken one cycle later
    task automatic access(input logic wr, input logic rd, input logic [7:0] addr,
                          input logic [3:0] be, input logic [31:0] wdata,
                          output logic [31:0] rdata, output logic ack);
        @(posedge clock_in);
        cfg_out <= '{wr, rd, addr, be, wdata};
        @(posedge clock_in);
        // released lines show the inverse, not the last value
        cfg_out <= '{1'b0, 1'b0, ~addr, ~be, ~wdata};
        #1;
        rdata = rdata_in;
        ack = ack_in;
    endtask

endmodule // pch_host_model

// *** test/testbench.sv ***
/*
 * Self-checking bench for the configuration header slice: table of
 * register writes and read-backs, then address hits, class loads,
 * messaging-unit swap, reset survival and the master latency timer.
 * Assumes pch_pkg is compiled first.
 */
`timescale 1ns/100ps
module testbench;
    import pch_pkg::*;

    typedef struct packed {
        logic        local_sel;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
        logic [31:0] exp;
    } pch_tb_row_type;

    localparam pch_tb_row_type ROWS [0:7] = '{
        '{1'b0, 8'h0c, 4'hf, 32'hffffffff, 32'h0000fe00},
        '{1'b1, 8'h0c, 4'hf, 32'h00000a04, 32'h00000a04},
        '{1'b0, 8'h0c, 4'h1, 32'h000000ff, 32'h00000a00},
        '{1'b0, 8'h0c, 4'h1, 32'h00000008, 32'h00000a08},
        '{1'b0, 8'h08, 4'hf, 32'h0e000100, 32'h0680005a},
        '{1'b0, 8'h10, 4'hf, 32'hffffffff, 32'hfffff000},
        '{1'b1, 8'h10, 4'hf, 32'h12345fff, 32'h12345000},
        '{1'b0, 8'h14, 4'hf, 32'hffffffff, 32'h00000000}
    };

    logic clock_in, rst_b_in, mu_en, master_active;
    pch_access_type   cfg, lb;
    pch_eeprom_type   eeprom;
    pch_pci_addr_type pci_addr;
    logic [31:0] cfg_rdata, lb_rdata;
    logic        cfg_ack, lb_ack, reg_hit, fwd, rsvd, queues, intr_regs, line_eight, expired;
    logic [11:0] reg_index;
    int mismatches, checks;
    logic [31:0] r;

    pch_host_model i_pch_host_model (.clock_in(clock_in), .rdata_in(cfg_rdata),
        .ack_in(cfg_ack), .cfg_out(cfg));

    pch_config_regs i_pch_config_regs (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .cfg_in(cfg), .local_bus_in(lb), .eeprom_in(eeprom), .pci_addr_in(pci_addr),
        .messaging_unit_enable_in(mu_en), .master_active_in(master_active),
        .cfg_rdata_out(cfg_rdata), .cfg_ack_out(cfg_ack), .local_bus_rdata_out(lb_rdata),
        .local_bus_ack_out(lb_ack), .reg_hit_out(reg_hit), .reg_index_out(reg_index),
        .i2o_forward_out(fwd), .i2o_reserved_out(rsvd), .i2o_queues_out(queues),
        .i2o_intr_regs_out(intr_regs), .line_eight_out(line_eight),
        .latency_expired_out(expired));

    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cfg_rw(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                          input logic [31:0] wd, output logic [31:0] rd);
        logic a;
        i_pch_host_model.access(wr, !wr, addr, be, wd, rd, a);
        check({31'h0, a}, 32'h1);
    endtask

    task automatic lb_wr(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] wd);
        @(posedge clock_in);
        lb <= '{1'b1, 1'b0, addr, be, wd};
        @(posedge clock_in);
        lb <= '{1'b0, 1'b0, ~addr, ~be, ~wd};
        #1;
        check({31'h0, lb_ack}, 32'h1);
    endtask

    task automatic lb_rd(input logic [7:0] addr, input logic [31:0] exp);
        @(posedge clock_in);
        lb <= '{1'b0, 1'b1, addr, 4'h0, 32'h0};
        @(posedge clock_in);
        lb <= '{1'b0, 1'b0, ~addr, 4'hf, 32'hffffffff};
        #1;
        check({31'h0, lb_ack}, 32'h1);
        check(lb_rdata, exp);
    endtask

    task automatic hit(input logic [31:0] a);
        @(posedge clock_in);
        pci_addr <= '{1'b1, a};
        @(posedge clock_in);
        pci_addr <= '{1'b0, ~a};
        #1;
    endtask

    task automatic measure(input int lim);
        int n;
        @(posedge clock_in);
        master_active <= 1'b1;
        for (n = 1; n < 80; n++) begin
            @(posedge clock_in);
            #1;
            if (expired === 1'b1) break;
        end
        check({31'h0, n >= lim && n <= lim + 2}, 32'h1);
        @(posedge clock_in);
        master_active <= 1'b0;
        repeat (2) @(posedge clock_in);
        #1;
        check({31'h0, expired}, 32'h0);
    endtask

    task automatic do_reset();
        @(posedge clock_in);
        rst_b_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        rst_b_in <= 1'b1;
    endtask

    initial begin
        rst_b_in = 1'b0;
        mu_en = 1'b0;
        master_active = 1'b0;
        lb = '0;
        eeprom = '0;
        pci_addr = '0;
        mismatches = 0;
        checks = 0;
        repeat (2) @(posedge clock_in);
        rst_b_in <= 1'b1;
        cfg_rw(1'b0, 8'h08, 4'h0, 32'h0, r);
        check(r, {BASE_BRIDGE, SUB_RST, INTERFACE_CODE_A_RST, REVISION_VALUE});
        cfg_rw(1'b0, 8'h0c, 4'h0, 32'h0, r);
        check(r, 32'h0);
        hit(32'h00000034);
        check({31'h0, reg_hit}, 32'h0);
        for (int i = 0; i < 8; i++) begin
            if (ROWS[i].local_sel) lb_wr(ROWS[i].addr, ROWS[i].be, ROWS[i].wdata);
            else cfg_rw(1'b1, ROWS[i].addr, ROWS[i].be, ROWS[i].wdata, r);
            cfg_rw(1'b0, ROWS[i].addr, 4'h0, 32'h0, r);
            check(r, ROWS[i].exp);
        end
        check({31'h0, line_eight}, 32'h1);
        cfg_rw(1'b1, 8'h0c, 4'h1, 32'h0, r);
        #8;
        check({31'h0, line_eight}, 32'h0);
        hit(32'h12345034);
        check({19'h0, reg_hit, reg_index}, 32'h1034);
        hit(32'h12346034);
        check({31'h0, reg_hit}, 32'h0);
        lb_wr(8'h08, 4'hf, 32'h0e000100);
        lb_rd(8'h08, {BASE_I2O, SUB_I2O, INTERFACE_CODE_A_I2O_INTR, REVISION_VALUE});
        cfg_rw(1'b0, 8'h08, 4'h0, 32'h0, r);
        check(r, {BASE_I2O, SUB_I2O, INTERFACE_CODE_A_I2O_INTR, REVISION_VALUE});
        check({30'h0, queues, intr_regs}, 32'h3);
        @(posedge clock_in);
        eeprom <= '{1'b1, BASE_BRIDGE, SUB_RST, INTERFACE_CODE_A_RST};
        mu_en <= 1'b1;
        @(posedge clock_in);
        eeprom <= '{1'b0, 8'hff, 8'hff, 8'hff};
        cfg_rw(1'b0, 8'h08, 4'h0, 32'h0, r);
        check(r, 32'h0680005a);
        cfg_rw(1'b1, 8'h10, 4'hf, 32'habcd0fff, r);
        cfg_rw(1'b0, 8'h10, 4'h0, 32'h0, r);
        check(r, 32'habcd0000);
        cfg_rw(1'b0, 8'h18, 4'h0, 32'h0, r);
        check(r, 32'h12345000);
        hit(32'habcd0010);
        check({30'h0, rsvd, fwd}, 32'h2);
        hit(32'habcd2000);
        check({30'h0, rsvd, fwd}, 32'h1);
        do_reset();
        cfg_rw(1'b0, 8'h10, 4'h0, 32'h0, r);
        check(r, 32'habcd0000);
        cfg_rw(1'b0, 8'h18, 4'h0, 32'h0, r);
        check(r, 32'h0);
        measure(8);
        lb_wr(8'h0c, 4'h2, 32'h00002000);
        measure(32);
        end_of_test();
    end

    initial begin
        repeat (3000) @(posedge clock_in);
        mismatches++;
        end_of_test();
    end

endmodule // testbench
